//--- core/servo_status_params.svh
// Constants for the servo status output block
`ifndef SERVO_STATUS_PARAMS_SVH
`define SERVO_STATUS_PARAMS_SVH
`define CLK_HZ 25000000
`define STARTUP_MIN_MS 2500
`define STARTUP_MAX_MS 3500
`define STARTUP_MULTI_MIN_MS 3500
`define STARTUP_MULTI_MAX_MS 4000
`define STARTUP_MS_SINGLE 3000
`define STARTUP_MS_MULTI 3750
`define PULSE_MAX_KHZ 4600
`define PULSE_MIN_CYC ((`CLK_HZ / 1000 + `PULSE_MAX_KHZ - 1) / `PULSE_MAX_KHZ)
`define INDEX_MIN_US 400
`define INDEX_MIN_CYC (`CLK_HZ / 1000000 * `INDEX_MIN_US)
`define SA_TOL_ABS 20
`define ZSP_HYST 20
`define ZSP_INIT 50
`define ADDR_CTRL 8'h00
`define ADDR_INPOS 8'h04
`define ADDR_ZSP 8'h08
`define ADDR_BRAKE 8'h0C
`define ADDR_SCALE 8'h10
`define ADDR_STATUS 8'h14
`define ADDR_DOUT 8'h18
`define CTRL_RESET 32'h0000_0000
`define SCALE_RESET 32'h0000_0001
`endif

//--- core/servo_status_pkg.sv
// Types for the servo status output block
package servo_status_pkg;
  typedef enum logic [1:0] {
    MODE_POS = 2'b00,
    MODE_VEL = 2'b01,
    MODE_TRQ = 2'b10
  } ctrl_mode_t;
  typedef struct packed {
    logic alarm;
    logic convAlarm;
    logic warning;
    logic motorStopWarn;
    logic batCableWarn;
    logic batWarn;
    logic posUndetermined;
    logic servoOn;
    logic readyOnCmd;
    logic gainSw;
    logic gainSw2;
    logic closedLoop;
    logic speedAtLimit;
    logic torqueAtLimit;
  } drive_state_t;
  typedef struct packed {
    logic faultFree;
    logic inPos;
    logic ready;
    logic speedReached;
    logic warn;
    logic batWarn;
    logic stopWarn;
    logic gain1;
    logic gain2;
    logic posLost;
    logic tough;
    logic closedLoop;
    logic convStop;
    logic brake;
    logic speedLim;
    logic zeroSpeed;
    logic torqueLim;
    logic [2:0] user;
  } status_flags_t;
  typedef enum logic [1:0] {
    PH_00 = 2'b00,
    PH_01 = 2'b01,
    PH_11 = 2'b11,
    PH_10 = 2'b10
  } quad_phase_t;
endpackage

//--- core/servo_status_outputs.sv
// Status flag outputs and encoder pulse outputs of a servo drive
// Function
// - Fault-free off on protective shutdown; on after startup delay when alarm-free.
// - In-position while droop within range; not in velocity or torque mode.
// - Ready asserted whenever servo-on state entered.
// - Speed-reached low at servo-off; on within set speed +-(5% + 20).
// - Speed-reached always on at set speed <= 20; unavailable position/torque.
// - Warning flag on with any warning; off after startup delay otherwise.
// - Battery warning on for cable or battery warning; else off after delay.
// - Battery-less encoder keeps battery warning always off.
// - Motor-stop warning on for such warning; off after startup delay.
// - Gain-switch flags follow gain switching and gain switching two.
// - Position-lost while position undetermined; tough-drive always off.
// - Closed-loop flag while fully closed loop runs.
// - Converter-stop on at ready-on command; off on converter alarm.
// - Brake interlock off at servo-off or alarm; delay configurable.
// - Speed-limiting only in torque mode at limit; off at servo-off.
// - Zero-speed on at or below threshold, initial 50.
// - Zero-speed clears at threshold plus 20 in either direction.
// - Torque-limiting on at limit; off at servo-off and torque mode.
// - Host-written digital outputs drive user pins A, B, C.
// - Scaled quadrature output; B lags A on CCW; phase select reverses.
// - Quadrature edge rate never exceeds 4.6 M per second.
// - Single-axis index pulse per revolution, at least 400 us; multi-axis none.
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "servo_status_params.svh"
module servo_status_outputs
  import servo_status_pkg::*;
#(
  parameter int STARTUP_SINGLE_CYC = `CLK_HZ / 1000 * `STARTUP_MS_SINGLE,
  parameter int STARTUP_MULTI_CYC = `CLK_HZ / 1000 * `STARTUP_MS_MULTI,
  parameter int BRAKE_UNIT_CYC = `CLK_HZ / 1000
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic multiAxis,
  input wire logic batteryLess,
  input wire drive_state_t driveState,
  input wire ctrl_mode_t ctrlMode,
  input wire logic signed [31:0] droopPulses,
  input wire logic signed [15:0] motorSpeed,
  input wire logic signed [15:0] setSpeed,
  input wire logic encStep,
  input wire logic encDirCcw,
  input wire logic encZero,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output status_flags_t flagsOut,
  output logic quad_a_pulse,
  output logic quad_a_pulse_n,
  output logic quad_b_pulse,
  output logic quad_b_pulse_n,
  output logic index_pulse,
  output logic index_pulse_n
);
  // Registers
  logic [31:0] ctrl_r;
  logic [31:0] inPosRange_r;
  logic [15:0] zspThresh_r;
  logic [15:0] brakeDelay_r;
  logic [15:0] scale_r;
  logic [2:0] dout_r;
  // AXI state
  logic awHeld_r, wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  wire phaseSel = ctrl_r[0];
  // Strap pins come from outside the clock domain; two flops first
  logic [1:0] strapMeta_r;
  logic [1:0] strapSync_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strapMeta_r <= 2'b00;
      strapSync_r <= 2'b00;
    end else begin
      strapMeta_r <= {multiAxis, batteryLess};
      strapSync_r <= strapMeta_r;
    end
  end
  wire multiSync = strapSync_r[1];
  wire batLessSync = strapSync_r[0];
  // Startup delay
  // Counter freezes once started, so it never wraps
  logic [31:0] startCnt_r;
  logic started_r;
  wire [31:0] startLimit = multiSync ? STARTUP_MULTI_CYC : STARTUP_SINGLE_CYC;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      startCnt_r <= 32'h0;
      started_r <= 1'b0;
    end else if (!started_r) begin
      startCnt_r <= startCnt_r + 32'h1;
      started_r <= (startCnt_r + 32'h1 >= startLimit);
    end
  end
  // Speed arithmetic
  wire [15:0] absSpeed = motorSpeed[15] ? 16'(-motorSpeed) : motorSpeed;
  wire signed [17:0] speedErr = 18'(motorSpeed) - 18'(setSpeed);
  wire [17:0] absErr = speedErr[17] ? 18'(-speedErr) : 18'(speedErr);
  wire [15:0] absSet = setSpeed[15] ? 16'(-setSpeed) : setSpeed;
  wire [17:0] saTol = 18'(absSet / 16'd20) + 18'(`SA_TOL_ABS);
  wire [31:0] absDroop = droopPulses[31] ? 32'(-droopPulses) : droopPulses;
  // Flag evaluation
  logic zsp_r, conv_r, brake_r;
  logic [15:0] brakeCnt_r;
  wire anyAlarm = driveState.alarm;
  wire zspOn = absSpeed <= zspThresh_r;
  wire zspOff = 17'(absSpeed) >= 17'(zspThresh_r) + 17'(`ZSP_HYST);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      zsp_r <= 1'b0;
      conv_r <= 1'b0;
    end else begin
      zsp_r <= zspOn ? 1'b1 : (zspOff ? 1'b0 : zsp_r);
      if (driveState.convAlarm)
        conv_r <= 1'b0;
      else if (driveState.readyOnCmd)
        conv_r <= 1'b1;
    end
  end
  wire brakeOk = driveState.servoOn && !anyAlarm;
  logic [15:0] brakeSub_r;
  always_ff @(posedge mclk) begin
    if (!rst_n || !brakeOk) begin
      brakeCnt_r <= 16'h0;
      brakeSub_r <= 16'h0;
      brake_r <= 1'b0;
    end else if (brakeCnt_r >= brakeDelay_r) begin
      brake_r <= 1'b1;
    end else if (brakeSub_r >= 16'(BRAKE_UNIT_CYC - 1)) begin
      brakeSub_r <= 16'h0;
      brakeCnt_r <= brakeCnt_r + 16'h1;
    end else begin
      brakeSub_r <= brakeSub_r + 16'h1;
    end
  end
  status_flags_t flagsNxt;
  always_comb begin
    flagsNxt.faultFree = started_r && !anyAlarm;
    flagsNxt.inPos = ctrlMode == MODE_POS && absDroop <= inPosRange_r;
    flagsNxt.ready = driveState.servoOn;
    flagsNxt.speedReached = driveState.servoOn && ctrlMode == MODE_VEL &&
                            (absSet <= 16'(`SA_TOL_ABS) || absErr <= saTol);
    flagsNxt.warn = driveState.warning || !started_r;
    flagsNxt.batWarn = !batLessSync &&
                       (driveState.batCableWarn || driveState.batWarn || !started_r);
    flagsNxt.stopWarn = driveState.motorStopWarn || !started_r;
    flagsNxt.gain1 = driveState.gainSw;
    flagsNxt.gain2 = driveState.gainSw2;
    flagsNxt.posLost = driveState.posUndetermined;
    flagsNxt.tough = 1'b0;
    flagsNxt.closedLoop = driveState.closedLoop;
    flagsNxt.convStop = conv_r;
    flagsNxt.brake = brake_r;
    flagsNxt.speedLim = driveState.servoOn && ctrlMode == MODE_TRQ && driveState.speedAtLimit;
    flagsNxt.zeroSpeed = zsp_r;
    flagsNxt.torqueLim = driveState.servoOn && ctrlMode != MODE_TRQ && driveState.torqueAtLimit;
    flagsNxt.user = dout_r;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n)
      flagsOut <= '0;
    else
      flagsOut <= flagsNxt;
  end
  // Encoder pulse scaling: one output step per scale_r input steps
  logic [15:0] scaleCnt_r;
  logic [7:0] pending_r;
  logic pendDir_r;
  logic [7:0] gapCnt_r;
  quad_phase_t phase_r, phaseNxt;
  wire scaledStep = encStep && scaleCnt_r + 16'h1 >= scale_r;
  wire advance = encDirCcw ^ phaseSel;
  wire canStep = gapCnt_r == 8'h0 && pending_r != 8'h0;
  always_comb begin
    case (phase_r)
      PH_00: phaseNxt = pendDir_r ? PH_01 : PH_10;
      PH_01: phaseNxt = pendDir_r ? PH_11 : PH_00;
      PH_11: phaseNxt = pendDir_r ? PH_10 : PH_01;
      PH_10: phaseNxt = pendDir_r ? PH_00 : PH_11;
      default: phaseNxt = PH_00;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scaleCnt_r <= 16'h0;
      pending_r <= 8'h0;
      pendDir_r <= 1'b0;
      gapCnt_r <= 8'h0;
      phase_r <= PH_00;
    end else begin
      if (encStep)
        scaleCnt_r <= scaledStep ? 16'h0 : scaleCnt_r + 16'h1;
      if (canStep) begin
        phase_r <= phaseNxt;
        gapCnt_r <= 8'(`PULSE_MIN_CYC - 1);
      end else if (gapCnt_r != 8'h0) begin
        gapCnt_r <= gapCnt_r - 8'h1;
      end
      // Backlog saturates; excess steps at overspeed are dropped
      if (scaledStep && (pending_r == 8'h0 || advance == pendDir_r)) begin
        pendDir_r <= advance;
        if (!canStep && pending_r != 8'hFF)
          pending_r <= pending_r + 8'h1;
      end else if (scaledStep) begin
        if (!canStep)
          pending_r <= pending_r - 8'h1;
      end else if (canStep) begin
        pending_r <= pending_r - 8'h1;
      end
    end
  end
  // Phase bit 0 is A, bit 1 is B; B lags A on advance
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      quad_a_pulse <= 1'b0;
      quad_a_pulse_n <= 1'b1;
      quad_b_pulse <= 1'b0;
      quad_b_pulse_n <= 1'b1;
    end else begin
      quad_a_pulse <= phase_r[0];
      quad_a_pulse_n <= ~phase_r[0];
      quad_b_pulse <= phase_r[1];
      quad_b_pulse_n <= ~phase_r[1];
    end
  end
  logic [15:0] idxCnt_r;
  wire idxActive = encZero || idxCnt_r != 16'h0;
  always_ff @(posedge mclk) begin
    if (!rst_n || multiSync) begin
      idxCnt_r <= 16'h0;
      index_pulse <= 1'b0;
      index_pulse_n <= 1'b1;
    end else begin
      if (encZero)
        idxCnt_r <= 16'(`INDEX_MIN_CYC);
      else if (idxCnt_r != 16'h0)
        idxCnt_r <= idxCnt_r - 16'h1;
      index_pulse <= idxActive;
      index_pulse_n <= !idxActive;
    end
  end
  // AXI4-Lite slave; writes applied once address and data are both held
  // Refused writes still answer, with an error code and no effect
  wire doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
  wire wMapped = awAddr_r <= `ADDR_DOUT && awAddr_r[1:0] == 2'b00 && awAddr_r != `ADDR_STATUS;
  wire [7:0] rAddr = s_axi_araddr[7:0];
  wire rInRange = s_axi_araddr[31:8] == 24'h0;
  // Status read sees the flags one cycle old
  logic [31:0] rdMux;
  logic rdOk;
  always_comb begin
    rdOk = rInRange;
    case (rAddr)
      `ADDR_CTRL: rdMux = ctrl_r;
      `ADDR_INPOS: rdMux = inPosRange_r;
      `ADDR_ZSP: rdMux = {16'h0, zspThresh_r};
      `ADDR_BRAKE: rdMux = {16'h0, brakeDelay_r};
      `ADDR_SCALE: rdMux = {16'h0, scale_r};
      `ADDR_STATUS: rdMux = {12'h0, flagsOut};
      `ADDR_DOUT: rdMux = {29'h0, dout_r};
      default: begin
        rdMux = 32'h0;
        rdOk = 1'b0;
      end
    endcase
  end
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    for (int i = 0; i < 4; i++)
      if (st[i])
        old[i*8 +: 8] = nw[i*8 +: 8];
    return old;
  endfunction
  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready = !wHeld_r;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0;
      ctrl_r <= `CTRL_RESET;
      inPosRange_r <= 32'h0;
      zspThresh_r <= 16'(`ZSP_INIT);
      brakeDelay_r <= 16'h0;
      scale_r <= 16'(`SCALE_RESET);
      dout_r <= 3'h0;
    end else begin
      if (s_axi_awvalid && !awHeld_r) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr[31:8] == 24'h0 ? s_axi_awaddr[7:0] : 8'hFF;
      end
      if (s_axi_wvalid && !wHeld_r) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wMapped ? 2'b00 : 2'b10;
        case (awAddr_r)
          `ADDR_CTRL: ctrl_r <= merge(ctrl_r, wData_r, wStrb_r);
          `ADDR_INPOS: inPosRange_r <= merge(inPosRange_r, wData_r, wStrb_r);
          `ADDR_ZSP: zspThresh_r <= 16'(merge({16'h0, zspThresh_r}, wData_r, wStrb_r));
          `ADDR_BRAKE: brakeDelay_r <= 16'(merge({16'h0, brakeDelay_r}, wData_r, wStrb_r));
          `ADDR_SCALE: scale_r <= 16'(merge({16'h0, scale_r}, wData_r, wStrb_r));
          `ADDR_DOUT: dout_r <= wStrb_r[0] ? wData_r[2:0] : dout_r;
          default: ;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdOk ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // servo_status_outputs

//--- verif/servo_status_props.sv
// Assertion checker for the servo status outputs
`timescale 1ns/1ps
module servo_status_props
  import servo_status_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire drive_state_t driveState,
  input wire ctrl_mode_t ctrlMode,
  input wire status_flags_t flagsOut,
  input wire logic quad_a_pulse,
  input wire logic quad_a_pulse_n,
  input wire logic quad_b_pulse,
  input wire logic quad_b_pulse_n,
  input wire logic index_pulse,
  input wire logic index_pulse_n
);
  logic [15:0] idxHigh_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence quadEdge;
    $changed({quad_a_pulse, quad_b_pulse});
  endsequence
  sequence quadQuiet;
    $stable({quad_a_pulse, quad_b_pulse}) [*5];
  endsequence
  // Counter instead of a long repetition
  always_ff @(posedge mclk) begin
    if (!rst_n || !index_pulse) begin
      idxHigh_r <= 16'h0000;
    end else begin
      idxHigh_r <= idxHigh_r + 16'h0001;
    end
  end
  a_ready_follows: assert property ($past(rst_n) |-> flagsOut.ready == $past(driveState.servoOn))
    else $error("ready flag does not follow servo-on");
  a_gain_follows: assert property ($past(rst_n) |->
    {flagsOut.gain1, flagsOut.gain2} == $past({driveState.gainSw, driveState.gainSw2}))
    else $error("gain switch flags wrong");
  a_poslost_follows: assert property ($past(rst_n) |-> flagsOut.posLost == $past(driveState.posUndetermined))
    else $error("position lost flag wrong");
  a_tough_off: assert property (!flagsOut.tough)
    else $error("tough drive flag set");
  a_closed_loop: assert property ($past(rst_n) |-> flagsOut.closedLoop == $past(driveState.closedLoop))
    else $error("closed loop flag wrong");
  a_inpos_mode: assert property ($past(ctrlMode) != MODE_POS |-> !flagsOut.inPos)
    else $error("in-position set outside position mode");
  a_speed_limit: assert property ($past(rst_n) |-> flagsOut.speedLim == ($past(driveState.speedAtLimit)
    && $past(driveState.servoOn) && $past(ctrlMode) == MODE_TRQ))
    else $error("speed limiting flag wrong");
  a_torque_limit: assert property ($past(rst_n) |-> flagsOut.torqueLim == ($past(driveState.torqueAtLimit)
    && $past(driveState.servoOn) && $past(ctrlMode) != MODE_TRQ))
    else $error("torque limiting flag wrong");
  a_conv_alarm: assert property (driveState.convAlarm |-> ##2 !flagsOut.convStop)
    else $error("converter stop kept through alarm");
  a_brake_off: assert property (driveState.alarm || !driveState.servoOn |-> ##2 !flagsOut.brake)
    else $error("brake interlock on at servo-off or alarm");
  a_pulse_diff: assert property ({quad_a_pulse_n, quad_b_pulse_n, index_pulse_n}
    == ~{quad_a_pulse, quad_b_pulse, index_pulse})
    else $error("differential pair not complementary");
  a_quad_rate: assert property (quadEdge |=> quadQuiet)
    else $error("quadrature edges too close");
  a_index_width: assert property ($fell(index_pulse) |-> idxHigh_r >= 16'h2710)
    else $error("index pulse too short");
endmodule // servo_status_props

//--- verif/pulse_reader.sv
// Controller-side reader of the encoder pulse outputs
`timescale 1ns/1ps
module pulse_reader (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic qa,
  input wire logic qb,
  input wire logic idx,
  output int pos,
  output int idxLen
);
  logic [1:0] prev_r;
  int run;
  always @(posedge mclk) begin
    if (!rst_n) begin
      prev_r <= 2'h0;
      pos <= 0;
      run <= 0;
      idxLen <= 0;
    end else begin
      prev_r <= {qa, qb};
      if ({qa, qb} != prev_r) begin
        pos <= (qa ^ prev_r[0]) ? pos + 1 : pos - 1;
      end
      run <= idx ? run + 1 : 0;
      if (!idx && run != 0) begin
        idxLen <= run;
      end
    end
  end
endmodule // pulse_reader

//--- verif/tb.sv
// Self-checking testbench for the servo status outputs
`timescale 1ns/1ps
module tb;
  import servo_status_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic multiAxis = 1'b0;
  logic batteryLess = 1'b0;
  logic encStep = 1'b0;
  logic encDirCcw = 1'b1;
  logic encZero = 1'b0;
  drive_state_t ds = '0;
  ctrl_mode_t ctrlMode = MODE_VEL;
  logic signed [15:0] motorSpeed = 16'sh0000;
  logic signed [15:0] setSpeed = 16'sh0000;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, q;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, s;
  logic qa, qan, qb, qbn, ix, ixn;
  status_flags_t flagsOut, f;
  int errors = 0;
  int checked = 0;
  int pos, idxLen;
  logic signed [15:0] zsSpd [8] = '{16'sh0046, 16'sh003C, 16'sh0032, 16'sh0045, 16'sh0046, 16'shFFCE, 16'shFFBB, 16'shFFBA};
  logic signed [15:0] saSet [5] = '{16'sh03E8, 16'sh03E8, 16'sh03E8, 16'sh03E8, 16'sh0014};
  logic signed [15:0] saSpd [5] = '{16'sh03A2, 16'sh03A1, 16'sh042E, 16'sh042F, 16'sh01F4};
  logic [7:0] zsExp = 8'h6C;
  logic [4:0] saExp = 5'h15;
  // Short startup and brake units keep the run small
  servo_status_outputs #(.STARTUP_SINGLE_CYC(20), .STARTUP_MULTI_CYC(30), .BRAKE_UNIT_CYC(2)) uut (
    .mclk(mclk), .rst_n(rst_n), .multiAxis(multiAxis), .batteryLess(batteryLess), .driveState(ds),
    .ctrlMode(ctrlMode), .droopPulses(32'sh00000000), .motorSpeed(motorSpeed), .setSpeed(setSpeed),
    .encStep(encStep), .encDirCcw(encDirCcw), .encZero(encZero), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .flagsOut(flagsOut), .quad_a_pulse(qa), .quad_a_pulse_n(qan), .quad_b_pulse(qb),
    .quad_b_pulse_n(qbn), .index_pulse(ix), .index_pulse_n(ixn));
  pulse_reader rdr (.mclk(mclk), .rst_n(rst_n), .qa(qa), .qb(qb), .idx(ix), .pos(pos), .idxLen(idxLen));
  always #20 mclk = ~mclk;
  // Sampled mid-cycle so no edge race
  always @(negedge mclk) f <= flagsOut;
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask
  task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    bit ha, hw, hr;
    n = 0;
    hr = 1'b0;
    s_axi_awaddr <= {24'h000000, a};
    s_axi_araddr <= {24'h000000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    while (!hr && n < 100) begin
      @(negedge mclk);
      ha = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
      hw = s_axi_wvalid && s_axi_wready;
      hr = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      s = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge mclk);
      if (ha) begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (hw) s_axi_wvalid <= 1'b0;
      if (hr) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
      n++;
    end
    // Let an edge pass so a next call never re-drives in one step
    @(posedge mclk);
    if (!hr) begin
      errors++;
      finish_test();
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    w(16);
    rst_n <= 1'b1;
    w(3);
    chk({f.faultFree, f.warn}, 2'h1);
    w(25);
    chk({f.faultFree, f.warn, f.batWarn, f.stopWarn}, 4'h8);
    done("startup");
    axi(1'b1, 8'h18, 32'h00000005);
    axi(1'b1, 8'h0C, 32'h00000003);
    w(2);
    chk(f.user, 3'h5);
    axi(1'b0, 8'h08, 32'h0);
    chk(q, 32'h00000032);
    axi(1'b0, 8'h40, 32'h0);
    chk({q, s}, 34'h2);
    done("registers");
    ds.warning <= 1'b1;
    ds.batWarn <= 1'b1;
    ds.motorStopWarn <= 1'b1;
    ds.gainSw <= 1'b1;
    ds.closedLoop <= 1'b1;
    ds.posUndetermined <= 1'b1;
    w(3);
    chk({f.warn, f.batWarn, f.stopWarn}, 3'h7);
    batteryLess <= 1'b1;
    w(4);
    chk(f.batWarn, 1'b0);
    for (int i = 0; i < 8; i++) begin
      motorSpeed <= zsSpd[i];
      w(4);
      chk(f.zeroSpeed, zsExp[i]);
    end
    ds.servoOn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      setSpeed <= saSet[i];
      motorSpeed <= saSpd[i];
      w(3);
      chk(f.speedReached, saExp[i]);
    end
    ctrlMode <= MODE_POS;
    w(3);
    chk(f.speedReached, 1'b0);
    chk(f.inPos, 1'b1);
    ctrlMode <= MODE_VEL;
    ds.servoOn <= 1'b0;
    w(3);
    chk(f.speedReached, 1'b0);
    done("flags");
    encStep <= 1'b1;
    w(8);
    encStep <= 1'b0;
    w(80);
    chk(pos, 8);
    axi(1'b1, 8'h00, 32'h00000001);
    encStep <= 1'b1;
    w(4);
    encStep <= 1'b0;
    w(60);
    chk(pos, 4);
    encZero <= 1'b1;
    w(1);
    encZero <= 1'b0;
    w(10050);
    chk(idxLen >= 10000, 1'b1);
    done("encoder");
    ds.servoOn <= 1'b1;
    ds.speedAtLimit <= 1'b1;
    ds.torqueAtLimit <= 1'b1;
    ctrlMode <= MODE_TRQ;
    w(3);
    chk({f.speedLim, f.torqueLim}, 2'h2);
    ctrlMode <= MODE_POS;
    ds.servoOn <= 1'b0;
    ds.readyOnCmd <= 1'b1;
    w(4);
    chk({f.convStop, f.brake, f.speedLim}, 3'h4);
    ds.servoOn <= 1'b1;
    w(3);
    chk({f.brake, f.torqueLim}, 2'h1);
    w(12);
    chk(f.brake, 1'b1);
    ds.alarm <= 1'b1;
    ds.convAlarm <= 1'b1;
    w(4);
    chk({f.faultFree, f.convStop, f.brake}, 3'h0);
    multiAxis <= 1'b1;
    w(4);
    encZero <= 1'b1;
    w(1);
    encZero <= 1'b0;
    w(2);
    chk({ix, ixn}, 2'h1);
    done("drive");
    finish_test();
  end
  // Whole sequence needs about 10500 cycles
  initial begin
    w(20000);
    errors++;
    finish_test();
  end
endmodule // tb
bind servo_status_outputs servo_status_props props_i (
  .mclk(mclk), .rst_n(rst_n), .driveState(driveState), .ctrlMode(ctrlMode), .flagsOut(flagsOut),
  .quad_a_pulse(quad_a_pulse), .quad_a_pulse_n(quad_a_pulse_n), .quad_b_pulse(quad_b_pulse),
  .quad_b_pulse_n(quad_b_pulse_n), .index_pulse(index_pulse), .index_pulse_n(index_pulse_n));
